// file: include/iid_params.svh
// Offsets, field positions, reset values and codes of the interface identifier register bank
// Functional notes
// [RQ1] Read-only 8-bit revision register holds a per-silicon fixed revision value.
// [RQ2] Identifier bits 23:20 and 12:9 read zero; bits 31:24 reserved, read-only.
// [RQ3] Bit 19 lock: writing 0 does nothing, writing 1 locks the selector.
// [RQ4] Lock clears on every platform init event, its only release.
// [RQ5] Selector bits 18:17: 00 picks legacy FIFO, 01 picks buffer; others reserved.
// [RQ6] Accepted selector writes take effect only at the next platform init event.
// [RQ7] Selector writes are accepted only while the lock reads 0.
// [RQ8] Bits 16:15 future capability flags, read-only, always zero.
// [RQ9] Bit 14 reports buffer interface implemented and selectable.
// [RQ10] Bit 13 reports legacy FIFO interface implemented and selectable.
// [RQ11] Bit 8 is 1 when localities 0 to 4 supported, else 0.
// [RQ12] Bits 7:4 report active version: 0001 buffer, 0000 FIFO.
// [RQ13] Bits 3:0 encode active interface: 0000 FIFO, 0001 buffer, 1111 old FIFO.
// [RQ14] Exactly one host interface is active at any time.
// [RQ15] Active kind governs the whole address range of all localities.
// [RQ16] This device never reports the legacy 1111 kind code.
// [RQ17] Writes to the kind field are ignored; it changes only at init.
// [RQ18] Kind 0000 reports all fields correctly with version 0.
// [RQ19] Kind 0001 reports all fields correctly with version 0001.
// [RQ20] Identifier aliased across localities; all copies share one storage.
// [RQ21] Legacy kind makes other identifier fields meaningless.
// [RQ22] Selector and lock change only when both capability bits are 1.
// [RQ23] Pending choice held until init, then loads kind and version together.
`ifndef IID_PARAMS_SVH
`define IID_PARAMS_SVH

`define IID_OFS_REVISION    12'h000
`define IID_OFS_IDENT       12'h004
`define IID_LOC_STRIDE_BITS 4'hc
`define IID_LOC_COUNT       3'h5
`define IID_BIT_LOCK        19
`define IID_SEL_HI          18
`define IID_SEL_LO          17
`define IID_BIT_BUF_CAP     14
`define IID_BIT_FIFO_CAP    13
`define IID_BIT_MULTI_LOC   8
`define IID_VER_HI          7
`define IID_VER_LO          4
`define IID_KIND_HI         3
`define IID_KIND_LO         0
`define IID_SEL_FIFO        2'h0
`define IID_SEL_BUF         2'h1
`define IID_KIND_FIFO       4'h0
`define IID_KIND_BUF        4'h1
`define IID_KIND_LEGACY     4'hf
`define IID_VER_FIFO        4'h0
`define IID_VER_BUF         4'h1
`define IID_RST_SEL         2'h0
`define IID_RST_LOCK        1'h0

`endif

// file: include/iid_pkg.sv
// Types shared by the interface identifier register bank
package iid_pkg;
  typedef enum logic [1:0] {
    IID_IF_FIFO = 2'h0,
    IID_IF_BUF  = 2'h1
  } iid_if_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } iid_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } iid_apb_rsp_t;

  typedef struct packed {
    logic    fifo_supported;
    logic    buf_supported;
    logic    multi_loc;
    logic [7:0] revision_value;
    iid_if_t reset_choice;
  } iid_cfg_t;

  typedef enum logic [2:0] {
    IID_ST_IDLE   = 3'b001,
    IID_ST_ACCESS = 3'b010,
    IID_ST_DONE   = 3'b100
  } iid_state_t;
endpackage : iid_pkg

// file: hw/iid_decode.sv
// Locality-aliasing address decoder for the identifier bank
`include "iid_params.svh"
module iid_decode (
  // Address in
  input  wire logic [15:0] paddr,
  // Decoded selects
  output logic             hit_revision,
  output logic             hit_ident
);
  logic [11:0] ofs;
  logic [3:0]  loc;

  // Any locality window maps to the same storage; upper nibble only gates range
  always_comb begin
    ofs          = paddr[11:0];
    loc          = paddr[15:12];
    hit_revision = (loc < {1'b0, `IID_LOC_COUNT}) && (ofs == `IID_OFS_REVISION); // [RQ20]
    hit_ident    = (loc < {1'b0, `IID_LOC_COUNT}) && (ofs == `IID_OFS_IDENT);    // [RQ20]
  end
endmodule // iid_decode

// file: hw/iid_regs.sv
// APB slave holding the revision and interface identifier registers
`include "iid_params.svh"
module iid_regs (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  // Platform initialization event, one-cycle pulse
  input  wire logic              platform_init_event,
  // Static build configuration
  input  wire iid_pkg::iid_cfg_t cfg,
  // APB
  input  wire iid_pkg::iid_apb_req_t apb_req,
  output iid_pkg::iid_apb_rsp_t  apb_rsp,
  // Active interface to the data path
  output iid_pkg::iid_if_t       active_if
);
  typedef struct packed {
    iid_pkg::iid_state_t st;
    logic                lock;
    iid_pkg::iid_if_t    pending;
    logic [3:0]          kind;
    logic [3:0]          version;
    logic [31:0]         rdata;
    logic                err;
    logic                booted;
  } iid_regs_state_t;

  iid_regs_state_t s_q;
  iid_regs_state_t s_d;
  logic            hit_revision;
  logic            hit_ident;
  logic            both_caps;
  logic [31:0]     ident_word;
  logic [31:0]     wd;

  iid_decode u_dec (
    .paddr        (apb_req.paddr),
    .hit_revision (hit_revision),
    .hit_ident    (hit_ident)
  );

  // Selector and lock are only writable when both interfaces exist
  assign both_caps = cfg.fifo_supported & cfg.buf_supported; // [RQ22]
  assign wd        = apb_req.pwdata;

  // Assemble the read image; reserved bits tie to zero
  always_comb begin
    ident_word                                = 32'h0000_0000; // [RQ2] [RQ8]
    ident_word[`IID_BIT_LOCK]                 = s_q.lock;
    ident_word[`IID_SEL_HI:`IID_SEL_LO]       = s_q.pending;
    ident_word[`IID_BIT_BUF_CAP]              = cfg.buf_supported;  // [RQ9]
    ident_word[`IID_BIT_FIFO_CAP]             = cfg.fifo_supported; // [RQ10]
    ident_word[`IID_BIT_MULTI_LOC]            = cfg.multi_loc;      // [RQ11]
    ident_word[`IID_VER_HI:`IID_VER_LO]       = s_q.version;        // [RQ12]
    ident_word[`IID_KIND_HI:`IID_KIND_LO]     = s_q.kind;           // [RQ13] [RQ16]
  end

  // Next-state logic: APB handshake plus selector, lock and init handling
  always_comb begin
    s_d = s_q;
    case (s_q.st)
      iid_pkg::IID_ST_IDLE: begin
        if (apb_req.psel && !apb_req.penable) begin
          s_d.st = iid_pkg::IID_ST_ACCESS;
        end
      end
      iid_pkg::IID_ST_ACCESS: begin
        // Answer one cycle after the access phase starts; data comes from flops
        s_d.st    = iid_pkg::IID_ST_DONE;
        s_d.err   = !(hit_revision || hit_ident);
        s_d.rdata = 32'h0000_0000;
        if (!apb_req.pwrite && hit_revision) begin
          s_d.rdata = {24'h00_0000, cfg.revision_value}; // [RQ1]
        end else if (!apb_req.pwrite && hit_ident) begin
          s_d.rdata = ident_word; // [RQ20]
        end
      end
      iid_pkg::IID_ST_DONE: begin
        s_d.st = iid_pkg::IID_ST_IDLE;
        // Write commits only on the completing edge; kind/version bits ignore it
        if (apb_req.pwrite && hit_ident && both_caps) begin // [RQ17] [RQ22]
          if (!s_q.lock && (wd[`IID_SEL_HI:`IID_SEL_LO] == `IID_SEL_FIFO ||
                            wd[`IID_SEL_HI:`IID_SEL_LO] == `IID_SEL_BUF)) begin // [RQ5] [RQ7]
            s_d.pending = iid_pkg::iid_if_t'(wd[`IID_SEL_HI:`IID_SEL_LO]); // [RQ6]
          end
          if (wd[`IID_BIT_LOCK]) begin
            s_d.lock = 1'b1; // [RQ3]
          end
        end
      end
      default: begin
        s_d.st = iid_pkg::IID_ST_IDLE;
      end
    endcase
    // First cycle after reset adopts the strapped choice, caught clocked not async
    if (!s_q.booted) begin
      s_d.booted  = 1'b1;
      s_d.pending = cfg.reset_choice;
    end
    // Init wins over a same-cycle lock write; kind and version load together
    if (platform_init_event || !s_q.booted) begin
      s_d.lock = `IID_RST_LOCK; // [RQ4]
      if ((s_d.pending == iid_pkg::IID_IF_BUF) ? cfg.buf_supported : !cfg.fifo_supported) begin
        s_d.kind    = `IID_KIND_BUF;  // [RQ19] [RQ23]
        s_d.version = `IID_VER_BUF;
      end else begin
        s_d.kind    = `IID_KIND_FIFO; // [RQ18] [RQ23]
        s_d.version = `IID_VER_FIFO;
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s_q.st      <= iid_pkg::IID_ST_IDLE;
      s_q.lock    <= `IID_RST_LOCK;
      s_q.pending <= iid_pkg::iid_if_t'(`IID_RST_SEL);
      s_q.kind    <= `IID_KIND_FIFO;
      s_q.version <= `IID_VER_FIFO;
      s_q.rdata   <= 32'h0000_0000;
      s_q.err     <= 1'b0;
      s_q.booted  <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Exactly one interface active, decoded from the kind field
  assign active_if       = (s_q.kind == `IID_KIND_BUF) ? iid_pkg::IID_IF_BUF : iid_pkg::IID_IF_FIFO; // [RQ14] [RQ15]
  // One assignment drives the whole answer, so no field has a second driver
  assign apb_rsp = '{pready:  (s_q.st == iid_pkg::IID_ST_DONE),
                     pslverr: (s_q.st == iid_pkg::IID_ST_DONE) && s_q.err,
                     prdata:  s_q.rdata};
  // Legacy kind is never produced, so all other fields stay meaningful [RQ21]
endmodule // iid_regs

// file: bench/iid_chk.sv
// Port assertions for the identifier register bank
module iid_chk (
  // Clock and reset
  input wire logic                  clk_sys,
  input wire logic                  rstn,
  // Inputs and answers
  input wire logic                  platform_init_event,
  input wire iid_pkg::iid_cfg_t     cfg,
  input wire iid_pkg::iid_apb_req_t apb_req,
  input wire iid_pkg::iid_apb_rsp_t apb_rsp,
  input wire iid_pkg::iid_if_t      active_if
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Completed good reads of each word
  logic ok_rd, id_rd;
  assign ok_rd = apb_rsp.pready && !apb_rsp.pslverr && !apb_req.pwrite;
  assign id_rd = ok_rd && apb_req.paddr[11:0] == 12'h004;
  rsv_zero_a: assert property (id_rd |-> apb_rsp.prdata[31:20] == 12'h0
    && apb_rsp.prdata[16:15] == 2'h0 && apb_rsp.prdata[12:9] == 4'h0) else $error("reserved bits set");
  rev_val_a: assert property (ok_rd && apb_req.paddr[11:0] == 12'h000
    |-> apb_rsp.prdata[7:0] == cfg.revision_value) else $error("revision wrong");
  cap_bits_a: assert property (id_rd |-> apb_rsp.prdata[14] == cfg.buf_supported
    && apb_rsp.prdata[13] == cfg.fifo_supported && apb_rsp.prdata[8] == cfg.multi_loc) else $error("caps wrong");
  kind_ver_a: assert property (id_rd
    |-> apb_rsp.prdata[7:0] == {2'h0, active_if, 2'h0, active_if}) else $error("kind or version wrong");
  // The one active interface must be one that this build implements
  one_if_a: assert property ((active_if == iid_pkg::IID_IF_BUF) ? cfg.buf_supported : cfg.fifo_supported)
    else $error("active interface not supported");
  // The first edge after release loads the reset choice, so it is skipped
  hold_if_a: assert property (!platform_init_event && $past(rstn) |=> $stable(active_if))
    else $error("active interface moved");
  rdy_lat_a: assert property (apb_req.psel && !apb_req.penable |=> !apb_rsp.pready ##1 apb_rsp.pready)
    else $error("answer latency wrong");
  unmap_a: assert property (apb_rsp.pready |-> apb_rsp.pslverr == !(apb_req.paddr[15:12] < 4'h5
    && apb_req.paddr[11:3] == 9'h0 && apb_req.paddr[1:0] == 2'h0)) else $error("error flag wrong");
endmodule // iid_chk

// file: bench/tb_top.sv
// Self-checking bench for the identifier register bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rstn, platform_init_event, er;
  logic [31:0] rd;
  iid_pkg::iid_cfg_t cfg;
  iid_pkg::iid_apb_req_t req;
  iid_pkg::iid_apb_rsp_t rsp;
  iid_pkg::iid_if_t act;
  int n_errors = 0, checked = 0, cyc = 0;
  iid_regs dut (.clk_sys(clk_sys), .rstn(rstn), .platform_init_event(platform_init_event), .cfg(cfg),
    .apb_req(req), .apb_rsp(rsp), .active_if(act));
  // 250 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Hang guard; the sequence needs under a hundred cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One transfer; an idle edge leads it so no signal is assigned twice in a step
  task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    // Ready is read as it stands at each rising edge; data is taken at that same edge
    do @(posedge clk_sys); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [31:0] exp, input string m);
    apb(a, 1'b0, 32'h0);
    chk(rd, exp, m);
    chk({31'h0, er}, 32'h0, m);
  endtask
  function automatic logic [31:0] idv(input logic lk, input logic [1:0] sel, input logic [3:0] k);
    return {12'h0, lk, sel, 2'h0, cfg.buf_supported, cfg.fifo_supported, 4'h0, cfg.multi_loc, k, k};
  endfunction
  task automatic init_pulse();
    @(posedge clk_sys);
    platform_init_event <= 1'b1;
    @(posedge clk_sys);
    platform_init_event <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic rst(input logic bufcap);
    rstn <= 1'b0;
    @(posedge clk_sys);
    cfg.buf_supported <= bufcap;
    cfg.multi_loc     <= bufcap;
    repeat (7) @(posedge clk_sys);
    rstn <= 1'b1;
  endtask
  task automatic wrap_up();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    platform_init_event = 1'b0;
    req = '0;
    cfg = '{1'b1, 1'b1, 1'b1, 8'ha5, iid_pkg::IID_IF_FIFO};
    rst(1'b1);
    rdc(16'h0000, 32'h0000_00a5, "revision");
    rdc(16'h0004, idv(1'b0, 2'h0, 4'h0), "ident reset");
    $display("reset test done");
    // Ones in every read-only bit, selector 01, lock 0, through locality 3
    apb(16'h3004, 1'b1, 32'hfff3_ffff);
    rdc(16'h4004, idv(1'b0, 2'h1, 4'h0), "alias");
    chk({30'h0, act}, 32'h0, "before init");
    apb(16'h0004, 1'b1, 32'h000a_0000);
    apb(16'h1004, 1'b1, 32'h0000_0000);
    rdc(16'h2004, idv(1'b1, 2'h1, 4'h0), "locked");
    init_pulse();
    chk({30'h0, act}, 32'h1, "after init");
    rdc(16'h0004, idv(1'b0, 2'h1, 4'h1), "buffer on");
    apb(16'h0004, 1'b1, 32'h0004_0000);
    rdc(16'h0004, idv(1'b0, 2'h1, 4'h1), "reserved code");
    apb(16'h0004, 1'b1, 32'h0);
    init_pulse();
    rdc(16'h0004, idv(1'b0, 2'h0, 4'h0), "fifo again");
    $display("select test done");
    // Unmapped read, then unmapped write that must not reach the selector
    for (int i = 0; i < 2; i++) begin
      apb(i ? 16'h0008 : 16'h5004, i[0], 32'h0002_0000);
      chk({31'h0, er}, 32'h1, "unmapped");
    end
    rdc(16'h0004, idv(1'b0, 2'h0, 4'h0), "dropped");
    // Second build: only the FIFO interface and a single locality
    rst(1'b0);
    apb(16'h0004, 1'b1, 32'h000a_0000);
    rdc(16'h0004, idv(1'b0, 2'h0, 4'h0), "one cap");
    $display("error test done");
    wrap_up();
  end
endmodule // tb_top
bind iid_regs iid_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .platform_init_event(platform_init_event),
  .cfg(cfg), .apb_req(apb_req), .apb_rsp(apb_rsp), .active_if(active_if));
